// >>> design/sms_pkg.sv
// Shared types and constants for the servo mode sequencer.
// Assumes one clock domain; one wedge strobe per servo sample.
package sms_pkg;

    // ----------------------------------------
    // Widths and fixed figures
    // ----------------------------------------
    localparam int TRK_W = 13;
    localparam int POS_W = 16;
    localparam int VEL_W = 16;
    localparam int CUR_W = 13;
    localparam int CNT_W = 8;
    localparam int FRAC_W = 8;
    localparam logic [TRK_W-1:0] LONG_SEEK_TRK = 13'h0050;
    localparam logic [TRK_W-1:0] SHORT_SEEK_TRK = 13'h0003;
    localparam logic [POS_W-1:0] QUARTER_TRK = 16'h0040;
    localparam logic [POS_W-1:0] HALF_TRK = 16'h0080;
    localparam logic [POS_W-1:0] BOUNDARY_TRK = 16'h0040;
    localparam logic [2:0] LOCK_LOSS_CNT = 3'h5;
    localparam logic [7:0] BURST_HALF = 8'h80;
    localparam logic [CUR_W-1:0] CUR_MAX = 13'h0FFF;
    localparam logic [CUR_W-1:0] CUR_ZERO = 13'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // ----------------------------------------
    // Control modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        SMS_IDLE = 3'h0,
        SMS_ACCEL = 3'h1,
        SMS_COAST = 3'h2,
        SMS_DECEL = 3'h3,
        SMS_LINVEL = 3'h4,
        SMS_SETTLE = 3'h5,
        SMS_FOLLOW = 3'h6
    } sms_mode_e;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
    } sms_burst_s;

    typedef struct packed {
        logic [TRK_W-1:0] gray_track;
        sms_burst_s bursts;
        logic sync_missing;
        logic sam_missing;
        logic gray_error;
        logic bump;
        logic defect;
    } sms_wedge_s;

    typedef struct packed {
        logic [POS_W-1:0] pos_limit;
        logic [VEL_W-1:0] vel_limit;
        logic [CNT_W-1:0] follow_count;
        logic [VEL_W-1:0] coast_vel;
    } sms_cfg_s;

    typedef struct packed {
        logic valid;
        logic [TRK_W-1:0] track;
        logic write_op;
        logic signed [POS_W-1:0] offset;
    } sms_cmd_s;

    typedef struct packed {
        logic signed [CUR_W-1:0] current;
        logic low_bw;
        logic update;
    } sms_drive_s;

endpackage

// >>> design/sms_gray_pes.sv
// Gray-to-binary track decode and burst-pair position error.
// Purely combinational; the caller registers the results.
module sms_gray_pes (
    input wire logic [sms_pkg::TRK_W-1:0] gray_track,
    input wire sms_pkg::sms_burst_s bursts,
    output logic [sms_pkg::TRK_W-1:0] bin_track,
    output logic signed [sms_pkg::POS_W-1:0] fine_pos
);
    logic signed [9:0] diff_ac;
    logic signed [9:0] diff_bd;
    logic [8:0] mag_ac;
    logic [8:0] mag_bd;

    // ----------------------------------------
    // Gray decode, one bit per stage
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < sms_pkg::TRK_W; gi++) begin : g_gray
            assign bin_track[gi] = ^gray_track[sms_pkg::TRK_W-1:gi];
        end
    endgenerate

    // ----------------------------------------
    // Burst-pair choice
    // ----------------------------------------
    // The A/C pair is linear near centre; B/D takes over off track.
    always_comb begin
        diff_ac = 10'(signed'({2'b00, bursts.a})) - 10'(signed'({2'b00, bursts.c}));
        diff_bd = 10'(signed'({2'b00, bursts.b})) - 10'(signed'({2'b00, bursts.d}));
        mag_ac = diff_ac[9] ? 9'(-diff_ac) : diff_ac[8:0];
        mag_bd = diff_bd[9] ? 9'(-diff_bd) : diff_bd[8:0];
        if (mag_ac <= mag_bd) begin
            fine_pos = sms_pkg::POS_W'(diff_ac);
        end else if (diff_bd[9]) begin
            fine_pos = sms_pkg::POS_W'(diff_ac) - sms_pkg::POS_W'(diff_bd);
        end else begin
            fine_pos = sms_pkg::POS_W'(diff_ac) + sms_pkg::POS_W'(diff_bd);
        end
    end
endmodule

// >>> design/sms_servo_mode_sequencer.sv
// Per-wedge control mode sequencer for head positioning.
// Assumes wedge data is synchronous to clk and valid with wedge_strobe.
// Position is in fractions of a track, FRAC_W bits below the track.

// Contract
// - One update per wedge strobe; code gives none for a strobe that comes with cmd.valid in the same cycle
// - Flags pick seek, settle or follow law
// - Long seek: accel, coast, decel, linear, settle
// - Medium seek starts in linear velocity
// - Short seek linear with low bandwidth
// - Track position and velocity every sample; code ignores a strobe that comes with cmd.valid in the same cycle
// - Seek to settle inside both limits
// - Settle beyond quarter track returns linear
// - Enough good samples: follow, write enabled for writes
// - Repeated bump drops write, returns linear
// - Writes follow on track, A equals C
// - Off-track offset held within half track; code clamps cmd.offset alone, and cmd.offset plus microjog is not clamped
// - Reads seek with microjog offset directly
// - Ignore gray errors beyond quarter offset
// - Apply microjog on read/write change
// - Four bursts, pair switch off track
// - Gray track number decoded to binary
// - Five missed sync/mark flags lock loss
module sms_servo_mode_sequencer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wedge_strobe,
    input wire sms_pkg::sms_wedge_s wedge,
    input wire sms_pkg::sms_cfg_s cfg,
    input wire sms_pkg::sms_cmd_s cmd,
    input wire logic signed [sms_pkg::POS_W-1:0] microjog,
    output sms_pkg::sms_drive_s drive,
    output logic write_enable,
    output logic [2:0] mode,
    output logic lock_lost,
    output logic seek_active
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        sms_pkg::sms_mode_e mode;
        logic [sms_pkg::TRK_W-1:0] target_trk;
        logic signed [sms_pkg::POS_W-1:0] offset;
        logic signed [sms_pkg::POS_W+sms_pkg::TRK_W-1:0] pos;
        logic signed [sms_pkg::VEL_W-1:0] vel;
        logic [sms_pkg::CNT_W-1:0] good_cnt;
        logic [2:0] miss_cnt;
        logic prev_err;
        logic write_op;
        logic low_bw;
        logic wen;
        logic lost;
        logic seek;
        logic [sms_pkg::TRK_W-1:0] last_trk;
        sms_pkg::sms_drive_s drive;
    } sms_state_s;

    sms_state_s st_reg;
    sms_state_s st_next;

    localparam int AW = sms_pkg::POS_W + sms_pkg::TRK_W;

    logic [sms_pkg::TRK_W-1:0] bin_track;
    logic signed [sms_pkg::POS_W-1:0] fine_pos;
    logic signed [AW-1:0] meas_pos;
    logic signed [AW-1:0] tgt_pos;
    logic signed [AW-1:0] err;
    logic [AW-1:0] err_mag;
    logic signed [sms_pkg::VEL_W-1:0] new_vel;
    logic [sms_pkg::VEL_W-1:0] vel_mag;
    logic [sms_pkg::TRK_W-1:0] seek_len;
    logic in_lim;
    logic gray_ok;
    logic missing;
    logic signed [AW-1:0] traj_vel;
    logic signed [AW-1:0] raw_cur;

    sms_gray_pes u_gray_pes (
        .gray_track(wedge.gray_track),
        .bursts(wedge.bursts),
        .bin_track(bin_track),
        .fine_pos(fine_pos)
    );

    // ----------------------------------------
    // Combinational measurement
    // ----------------------------------------
    always_comb begin
        meas_pos = AW'(signed'({1'b0, bin_track, {sms_pkg::FRAC_W{1'b0}}}))
            + AW'(fine_pos);
        tgt_pos = AW'(signed'({1'b0, st_reg.target_trk, {sms_pkg::FRAC_W{1'b0}}}))
            + AW'(st_reg.offset);
        err = tgt_pos - meas_pos;
        err_mag = err[AW-1] ? AW'(-err) : err;
        new_vel = sms_pkg::VEL_W'(meas_pos - st_reg.pos);
        vel_mag = new_vel[sms_pkg::VEL_W-1] ? sms_pkg::VEL_W'(-new_vel) : new_vel;
        in_lim = (err_mag <= AW'(cfg.pos_limit)) && (vel_mag <= cfg.vel_limit);
        // Boundary gray errors are soft while far off track
        gray_ok = !wedge.gray_error
            || (st_reg.offset > signed'(sms_pkg::BOUNDARY_TRK))
            || (st_reg.offset < -signed'(sms_pkg::BOUNDARY_TRK));
        missing = wedge.sync_missing || wedge.sam_missing;
        // Wedge fields are only valid with the strobe, so use the last decoded track
        seek_len = (cmd.track > st_reg.last_trk) ? cmd.track - st_reg.last_trk
            : st_reg.last_trk - cmd.track;
        // Phase-plane guide: allowed speed grows with remaining distance
        traj_vel = err >>> 2;
        raw_cur = traj_vel - AW'(new_vel);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.drive.update = 1'b0;
        if (cmd.valid) begin
            st_next.target_trk = cmd.track;
            st_next.write_op = cmd.write_op;
            st_next.wen = 1'b0;
            st_next.good_cnt = sms_pkg::CNT_ZERO;
            // Writes stay centred on A equal C; reads add the commanded offset
            if (cmd.write_op) begin
                st_next.offset = '0;
            end else if (cmd.offset > signed'(sms_pkg::HALF_TRK)) begin
                st_next.offset = signed'(sms_pkg::HALF_TRK);
            end else if (cmd.offset < -signed'(sms_pkg::HALF_TRK)) begin
                st_next.offset = -signed'(sms_pkg::HALF_TRK);
            end else begin
                st_next.offset = cmd.offset + microjog;
            end
            if (cmd.write_op != st_reg.write_op && cmd.offset == '0 && !cmd.write_op) begin
                st_next.offset = microjog;
            end
            st_next.low_bw = 1'b0;
            if (seek_len > sms_pkg::LONG_SEEK_TRK) begin
                st_next.mode = sms_pkg::SMS_ACCEL;
            end else if (seek_len < sms_pkg::SHORT_SEEK_TRK) begin
                st_next.mode = sms_pkg::SMS_LINVEL;
                st_next.low_bw = 1'b1;
            end else begin
                st_next.mode = sms_pkg::SMS_LINVEL;
            end
        end else if (wedge_strobe) begin
            st_next.drive.update = 1'b1;
            st_next.pos = meas_pos;
            st_next.vel = new_vel;
            st_next.last_trk = bin_track;
            if (missing) begin
                if (st_reg.miss_cnt != sms_pkg::LOCK_LOSS_CNT) begin
                    st_next.miss_cnt = st_reg.miss_cnt + 3'h1;
                end
            end else begin
                st_next.miss_cnt = 3'h0;
            end
            st_next.prev_err = wedge.bump || missing || !gray_ok || wedge.defect;
            unique case (st_reg.mode)
                sms_pkg::SMS_IDLE: begin
                    st_next.drive.current = sms_pkg::CUR_ZERO;
                end
                sms_pkg::SMS_ACCEL: begin
                    st_next.drive.current = err[AW-1] ? -sms_pkg::CUR_MAX : sms_pkg::CUR_MAX;
                    if (vel_mag >= cfg.coast_vel) begin
                        st_next.mode = sms_pkg::SMS_COAST;
                    end
                    if (AW'(vel_mag) >= (err_mag >> 2)) begin
                        st_next.mode = sms_pkg::SMS_DECEL;
                    end
                end
                sms_pkg::SMS_COAST: begin
                    st_next.drive.current = sms_pkg::CUR_ZERO;
                    if (AW'(vel_mag) >= (err_mag >> 2)) begin
                        st_next.mode = sms_pkg::SMS_DECEL;
                    end
                end
                sms_pkg::SMS_DECEL: begin
                    st_next.drive.current = sms_pkg::CUR_W'(raw_cur);
                    if (err_mag <= AW'({sms_pkg::LONG_SEEK_TRK, {sms_pkg::FRAC_W{1'b0}}} >> 4))
                    begin
                        st_next.mode = sms_pkg::SMS_LINVEL;
                    end
                end
                sms_pkg::SMS_LINVEL: begin
                    st_next.drive.current = st_reg.low_bw ? sms_pkg::CUR_W'(raw_cur >>> 1)
                        : sms_pkg::CUR_W'(raw_cur);
                    if (in_lim) begin
                        st_next.mode = sms_pkg::SMS_SETTLE;
                        st_next.good_cnt = sms_pkg::CNT_ONE;
                    end
                end
                sms_pkg::SMS_SETTLE: begin
                    st_next.drive.current = sms_pkg::CUR_W'(err >>> 1);
                    if (err_mag > AW'(sms_pkg::QUARTER_TRK)) begin
                        st_next.mode = sms_pkg::SMS_LINVEL;
                        st_next.good_cnt = sms_pkg::CNT_ZERO;
                    end else if (!in_lim) begin
                        st_next.good_cnt = sms_pkg::CNT_ZERO;
                    end else if (st_reg.good_cnt + sms_pkg::CNT_ONE >= cfg.follow_count) begin
                        st_next.mode = sms_pkg::SMS_FOLLOW;
                        st_next.wen = st_reg.write_op;
                    end else begin
                        st_next.good_cnt = st_reg.good_cnt + sms_pkg::CNT_ONE;
                    end
                end
                sms_pkg::SMS_FOLLOW: begin
                    st_next.drive.current = sms_pkg::CUR_W'(err >>> 1);
                    if (wedge.bump && st_reg.prev_err) begin
                        st_next.wen = 1'b0;
                        st_next.mode = sms_pkg::SMS_LINVEL;
                        st_next.good_cnt = sms_pkg::CNT_ZERO;
                    end
                end
                default: begin
                    st_next.mode = sms_pkg::SMS_IDLE;
                    st_next.drive.current = sms_pkg::CUR_ZERO;
                end
            endcase
            // Lock loss overrides the mode and write enable the mode law chose
            if (missing && st_reg.miss_cnt == sms_pkg::LOCK_LOSS_CNT - 3'h1) begin
                st_next.lost = 1'b1;
                st_next.wen = 1'b0;
                st_next.mode = sms_pkg::SMS_IDLE;
            end
        end
        st_next.drive.low_bw = st_next.low_bw;
        st_next.seek = (st_next.mode != sms_pkg::SMS_IDLE);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign drive = st_reg.drive;
    assign write_enable = st_reg.wen;
    assign mode = st_reg.mode;
    assign lock_lost = st_reg.lost;
    assign seek_active = st_reg.seek;

endmodule

// >>> verif/sms_chk.sv
// Port-level assertions for the servo mode sequencer.
// Sees only the top module's ports; one clock domain, sync reset.
module sms_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wedge_strobe,
    input wire sms_pkg::sms_cmd_s cmd,
    input wire sms_pkg::sms_drive_s drive,
    input wire logic write_enable,
    input wire logic [2:0] mode,
    input wire logic lock_lost,
    input wire logic seek_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_update_on_strobe: assert property (
        wedge_strobe && !cmd.valid |=> drive.update)
        else $error("no update after wedge strobe");
    a_update_cause: assert property (
        drive.update |-> $past(wedge_strobe) && !$past(cmd.valid))
        else $error("update without a taken wedge");
    a_mode_cause: assert property (
        mode != $past(mode) |-> $past(wedge_strobe) || $past(cmd.valid))
        else $error("mode changed without wedge or command");
    a_seek_flag: assert property (seek_active == (mode != 3'h0))
        else $error("seek flag disagrees with mode");
    a_reset_idle: assert property (
        $rose(resetn) |-> mode == 3'h0 && !write_enable && !lock_lost)
        else $error("outputs not idle after reset");
    a_wen_follow: assert property (write_enable |-> mode == sms_pkg::SMS_FOLLOW)
        else $error("write enabled outside follow");
    a_lock_sticky: assert property (lock_lost |=> lock_lost)
        else $error("lock loss flag cleared");
    a_lock_idle: assert property ($rose(lock_lost) |-> mode == 3'h0 && !write_enable)
        else $error("lock loss left seek or write active");
    a_long_order: assert property (
        $past(mode) == sms_pkg::SMS_ACCEL && mode != sms_pkg::SMS_ACCEL
        && !$past(cmd.valid) |-> mode inside {sms_pkg::SMS_COAST, sms_pkg::SMS_DECEL, 3'h0})
        else $error("acceleration left out of order");
endmodule

bind sms_servo_mode_sequencer sms_chk u_chk (.clk(clk), .resetn(resetn),
    .wedge_strobe(wedge_strobe), .cmd(cmd), .drive(drive), .write_enable(write_enable),
    .mode(mode), .lock_lost(lock_lost), .seek_active(seek_active));

// >>> verif/sms_demod_model.sv
// Demodulator model: turns a head track into one decoded wedge.
// Assumes the bench asks for a wedge with a one-cycle go pulse.
module sms_demod_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic [sms_pkg::TRK_W-1:0] head_track,
    input wire logic [1:0] faults,
    output logic wedge_strobe,
    output sms_pkg::sms_wedge_s wedge
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wedge_strobe <= 1'b0;
            wedge <= '0;
        end else if (go) begin
            wedge_strobe <= 1'b1;
            wedge.gray_track <= head_track ^ (head_track >> 1);
            wedge.bursts <= {sms_pkg::BURST_HALF, head_track[0] ? 8'h00 : 8'hFF,
                sms_pkg::BURST_HALF, sms_pkg::BURST_HALF};
            wedge.sync_missing <= faults[0];
            wedge.sam_missing <= 1'b0;
            wedge.gray_error <= 1'b0;
            wedge.bump <= faults[1];
            wedge.defect <= 1'b0;
        end else begin
            wedge_strobe <= 1'b0;
            // Stale fields toggle so nothing leans on old values
            wedge <= ~wedge;
        end
    end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the servo mode sequencer.
// Assumes the demodulator model supplies every wedge.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic go = 1'b0;
    logic [sms_pkg::TRK_W-1:0] head = '0;
    logic [1:0] faults = 2'h0;
    logic wedge_strobe;
    sms_pkg::sms_wedge_s wedge;
    sms_pkg::sms_cfg_s cfg = '{16'h0020, 16'h0020, 8'h03, 16'h0400};
    sms_pkg::sms_cmd_s cmd = '0;
    logic signed [sms_pkg::POS_W-1:0] jog = 16'sh0000;
    sms_pkg::sms_drive_s drive;
    logic write_enable;
    logic [2:0] mode;
    logic lock_lost;
    logic seek_active;
    int mismatches = 0;
    int n_checks = 0;

    always #2.5 clk = ~clk;

    sms_demod_model u_demod (.clk(clk), .resetn(resetn), .go(go), .head_track(head),
        .faults(faults), .wedge_strobe(wedge_strobe), .wedge(wedge));
    sms_servo_mode_sequencer u_dut (.clk(clk), .resetn(resetn), .wedge_strobe(wedge_strobe),
        .wedge(wedge), .cfg(cfg), .cmd(cmd), .microjog(jog), .drive(drive),
        .write_enable(write_enable), .mode(mode), .lock_lost(lock_lost),
        .seek_active(seek_active));

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic send_wedge(input logic [12:0] trk, input logic [1:0] f);
        @(posedge clk);
        go <= 1'b1;
        head <= trk;
        faults <= f;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        chk("update", 16'h0001, {15'h0, drive.update});
    endtask

    task automatic send_cmd(input logic [12:0] trk, input logic wr);
        @(posedge clk);
        cmd <= '{1'b1, trk, wr, 16'sh0000};
        @(posedge clk);
        cmd.valid <= 1'b0;
        #1;
    endtask

    // Bounded: a mode never reached ends the run
    task automatic settle_at(input logic [12:0] trk, input logic [2:0] m);
        int i;
        for (i = 0; i < 12 && mode !== m; i++) begin
            send_wedge(trk, 2'h0);
        end
        chk("mode", {13'h0, m}, {13'h0, mode});
        if (mode !== m) begin
            tally_and_finish();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("mode", 16'h0000, {13'h0, mode});
        chk("wen", 16'h0000, {15'h0, write_enable});
        send_wedge(13'h0000, 2'h0);
        send_cmd(13'h0064, 1'b1);
        chk("mode", 16'h0001, {13'h0, mode});
        chk("seek", 16'h0001, {15'h0, seek_active});
        send_wedge(13'h000E, 2'h0);
        chk("current", 16'(sms_pkg::CUR_MAX), {3'h0, drive.current});
        for (int k = 2; k < 8; k++) send_wedge(13'(k * 14), 2'h0);
        chk("mode", 16'h0004, {13'h0, mode});
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1;
        chk("mode", 16'h0000, {13'h0, mode});
        send_wedge(13'h0000, 2'h0);
        send_cmd(13'h000A, 1'b1);
        chk("mode", 16'h0004, {13'h0, mode});
        send_wedge(13'h0000, 2'h0);
        chk("low_bw", 16'h0000, {15'h0, drive.low_bw});
        send_cmd(13'h0002, 1'b1);
        chk("mode", 16'h0004, {13'h0, mode});
        send_wedge(13'h0000, 2'h0);
        chk("low_bw", 16'h0001, {15'h0, drive.low_bw});
        send_cmd(13'h0028, 1'b1);
        settle_at(13'h0028, sms_pkg::SMS_SETTLE);
        settle_at(13'h0028, sms_pkg::SMS_FOLLOW);
        chk("wen", 16'h0001, {15'h0, write_enable});
        send_wedge(13'h0028, 2'h2);
        chk("mode", 16'h0006, {13'h0, mode});
        send_wedge(13'h0028, 2'h2);
        chk("mode", 16'h0004, {13'h0, mode});
        chk("wen", 16'h0000, {15'h0, write_enable});
        settle_at(13'h0028, sms_pkg::SMS_SETTLE);
        send_wedge(13'h0029, 2'h0);
        chk("mode", 16'h0004, {13'h0, mode});
        // Read with a small microjog: settles off centre, no write allowed
        @(posedge clk);
        jog <= 16'sh0010;
        send_cmd(13'h0028, 1'b0);
        settle_at(13'h0028, sms_pkg::SMS_SETTLE);
        settle_at(13'h0028, sms_pkg::SMS_FOLLOW);
        chk("wen", 16'h0000, {15'h0, write_enable});
        chk("jog_held", 16'h0001, {15'h0, (drive.current != '0)});
        repeat (4) send_wedge(13'h0029, 2'h1);
        chk("lock", 16'h0000, {15'h0, lock_lost});
        send_wedge(13'h0029, 2'h1);
        chk("lock", 16'h0001, {15'h0, lock_lost});
        chk("mode", 16'h0000, {13'h0, mode});
        tally_and_finish();
    end
endmodule
